// ### bench/intdec_pg_model.sv
// Purpose: stand-in for the reply pulse generator and dsp digitizer
// Assumes: dma ack answered after ackDelay cycles, one-cycle ack pulse
// Notes: pulse widths and counts are measured here for the bench to judge
`default_nettype none
module intdec_pg_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic digitizerTrigger,
   input wire logic replyStart,
   input wire logic replyDmaRequest,
   input wire logic [7:0] replyDmaData,
   input wire logic [3:0] ackDelay,
   output var logic replyDmaAck,
   output var logic [7:0] lastStart,
   output var int digCount,
   output var int begCount,
   output var int digWidth,
   output var int begWidth
);
   timeunit 1ns;
   timeprecision 1ps;
   int digRun;
   int begRun;
   int waitN;
   // slow acks keep the request standing, so its hold is exercised too
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         replyDmaAck <= 1'b0;
         lastStart <= 8'h00;
         waitN <= 0;
         {digCount, begCount, digWidth, begWidth, digRun, begRun} <= '0;
      end else begin
         replyDmaAck <= 1'b0;
         if (replyDmaRequest && !replyDmaAck) begin
            waitN <= (waitN >= ackDelay) ? 0 : waitN + 1;
            replyDmaAck <= (waitN >= ackDelay);
            if (waitN >= ackDelay) lastStart <= replyDmaData;
         end
         // widths counted in whole cycles, stored at the falling end
         digRun <= digitizerTrigger ? digRun + 1 : 0;
         begRun <= replyStart ? begRun + 1 : 0;
         if (!digitizerTrigger && digRun > 0) begin
            digWidth <= digRun;
            digCount <= digCount + 1;
         end
         if (!replyStart && begRun > 0) begin
            begWidth <= begRun;
            begCount <= begCount + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ### bench/tb.sv
// Purpose: self-checking bench for the interrogation decoder
// Assumes: inputs driven at the falling edge, reply delay shortened
// Notes: frames are built bit by bit from uplink fields
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import intdec_pkg::*;
   localparam int RD = 3000;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   intdec_bus_req_t busReq = '{1'b1, 1'b1, 1'b1, 8'h00, 8'h00};
   logic [7:0] busRdData, replyDmaData, lastStart;
   logic videoIn = 1'b0, thresholdIn = 1'b0, dpskPhase = 1'b0, pol = 1'b0;
   logic digitizerTrigger, replyStart, decodeDoneIrq, replyDmaRequest, replyDmaAck;
   logic begPrev = 1'b0, digPrev = 1'b0;
   logic [3:0] ackDelay = 4'h0;
   logic [23:0] powerUpAddr = 24'hA5_3C96;
   int digCount, begCount, digWidth, begWidth, cyc = 0, begAt = 0, digAt = 0, p1At = 0, sprAt = 0, p3At = 0;
   int n_fail = 0, checks_done = 0;

   intdec_core #(.REPLY_DELAY_CYC(RD)) dut_u (.ref_clk, .rst, .busReq, .busRdData, .powerUpAddr, .videoIn,
      .thresholdIn, .dpskPhase, .digitizerTrigger, .replyStart, .decodeDoneIrq, .replyDmaRequest,
      .replyDmaData, .replyDmaAck);
   intdec_pg_model pg_u (.ref_clk, .rst, .digitizerTrigger, .replyStart, .replyDmaRequest, .replyDmaData,
      .ackDelay, .replyDmaAck, .lastStart, .digCount, .begCount, .digWidth, .begWidth);

   // clock and a cycle count for timing stamps
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;
   // rise stamps taken where outputs are settled
   always @(negedge ref_clk) begin
      begPrev <= replyStart;
      digPrev <= digitizerTrigger;
      if (replyStart && !begPrev) begAt <= cyc;
      if (digitizerTrigger && !digPrev) digAt <= cyc;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk) busReq <= '{1'b0, 1'b1, 1'b0, a, d};
      @(negedge ref_clk) busReq <= '{1'b1, 1'b1, 1'b1, a, d};
   endtask

   // data is registered, so it is taken one falling edge after the request
   task automatic rd(input logic [7:0] a, output logic [7:0] d, input logic cs = 1'b0);
      @(negedge ref_clk) busReq <= '{cs, 1'b0, 1'b1, a, 8'h00};
      @(negedge ref_clk) d = busRdData;
      busReq <= '{1'b1, 1'b1, 1'b1, a, 8'h00};
   endtask

   task automatic hold(input logic v, input int n);
      @(negedge ref_clk);
      videoIn <= v ^ pol;
      thresholdIn <= v ^ pol;
      repeat (n - 1) @(negedge ref_clk);
   endtask

   // P1, P2, P6 then sync reversal and dpsk chips, a reversal marks a one
   task automatic ms_frame(input logic [4:0] uf, input logic rl, aq, input logic [23:0] ap, input logic spr);
      logic [1:112] b;
      int n;
      b = '0;
      b[1:5] = uf;
      b[9] = rl;
      b[14] = aq;
      n = (uf == UF_LONG) ? 112 : 56;
      b[n-23 +: 24] = ap;
      p1At = cyc;
      hold(1, 80); hold(0, 120); hold(1, 80); hold(0, 70); hold(1, 110);
      if (spr) begin
         @(negedge ref_clk) dpskPhase <= ~dpskPhase;
         sprAt = cyc;
         repeat (50) @(negedge ref_clk);
         for (int i = 1; i <= n; i++) begin
            if (b[i]) dpskPhase <= ~dpskPhase;
            repeat (25) @(negedge ref_clk);
         end
      end else repeat (150) @(negedge ref_clk);
      hold(0, 1);
   endtask

   // P1, optional P2' and P2, then P3 and P4 two microseconds apart
   task automatic atc(input logic p2, input logic p2b);
      p1At = cyc;
      hold(1, 80); hold(0, 20); hold(p2b, 80); hold(0, 20); hold(p2, 80); hold(0, 520);
      p3At = cyc;
      hold(1, 80); hold(0, 120); hold(1, 80); hold(0, 1);
   endtask

   // interrupt service: read back, then pulse the hold bit to clear
   task automatic svc(input logic [7:0] ctrl, st, input logic [23:0] rx, input logic [7:0] start, input logic ms);
      logic [7:0] d;
      int w;
      w = 0;
      while (decodeDoneIrq !== 1'b1 && w < 4000) begin
         @(negedge ref_clk);
         w++;
      end
      chk(decodeDoneIrq, 1, "irq raised");
      rd(ADDR_STATUS, d); chk(d, st, "status");
      if (ms) begin
         rd(ADDR_RX_LOW, d); chk(d, rx[7:0], "rx low");
         rd(ADDR_RX_MID, d); chk(d, rx[15:8], "rx mid");
         rd(ADDR_RX_HIGH, d); chk(d, rx[23:16], "rx high");
         rd(ADDR_REPLY_START, d); chk(d, start, "start");
      end
      wr(ADDR_CONTROL, ctrl | 8'h01);
      @(negedge ref_clk);
      chk({decodeDoneIrq, replyDmaRequest}, 0, "cleared");
      wr(ADDR_CONTROL, ctrl);
   endtask

   // unmapped, write-only and out-of-window reads, manual trigger while held
   task automatic t_regs;
      logic [7:0] d;
      int dc;
      logic [7:0] ba[4] = '{8'h60, 8'h61, 8'h64, 8'h70};
      dc = digCount;
      foreach (ba[i]) begin
         rd(ba[i], d); chk(d, 8'h00, "blank read");
      end
      wr(ADDR_MANUAL_TRIG, 8'h5A);
      repeat (10) @(negedge ref_clk);
      chk(24'(digCount), 24'(dc + 1), "manual trigger");
      $display("test regs done");
   endtask

   // all four reply choices; first frame uses the power-up address
   task automatic t_modes;
      logic [4:0] uf[4] = '{UF_SHORT, UF_LONG, UF_SHORT, UF_LONG};
      logic [7:0] sa[4] = '{START_DF0_TRACK, START_DF16_TRACK, START_DF0_ACQ, START_DF16_ACQ};
      logic [23:0] own;
      int dc;
      int bc;
      own = powerUpAddr;
      wr(ADDR_CONTROL, 8'h02);
      for (int k = 0; k < 4; k++) begin
         if (k == 1) begin
            own = 24'h1C_E0F3;
            wr(ADDR_OWN_LOW, own[7:0]); wr(ADDR_OWN_MID, own[15:8]); wr(ADDR_OWN_HIGH, own[23:16]);
         end
         ackDelay = 4'(k * 3);
         dc = digCount;
         bc = begCount;
         ms_frame(uf[k], k[0], k[1], own, 1'b1);
         svc(8'h02, {3'b000, k[1], k[0], uf[k] == UF_LONG, uf[k] == UF_SHORT, 1'b1}, own, sa[k], 1'b1);
         chk(lastStart, sa[k], "dma start");
         chk({24'(digCount - dc), 24'(digWidth)}, {24'd1, 24'd5}, "dig pulse");
         chk(24'(digAt - p1At inside {[11:16]}), 1, "dig delay");
         chk({24'(begCount - bc), 24'(begWidth)}, {24'd1, 24'd10}, "reply pulse");
         chk(24'(begAt - sprAt inside {[RD:RD+3]}), 1, "reply delay");
      end
      $display("test modes done");
   endtask

   // lone video, held decoder, suppressed triggers with foreign address, no reversal
   task automatic t_faults;
      int dc;
      int bc;
      logic [7:0] d;
      dc = digCount;
      bc = begCount;
      @(negedge ref_clk) videoIn <= 1'b1;
      repeat (80) @(negedge ref_clk);
      videoIn <= 1'b0;
      repeat (700) @(negedge ref_clk);
      chk({decodeDoneIrq, 24'(digCount - dc)}, 0, "video alone");
      wr(ADDR_CONTROL, 8'h03);
      ms_frame(UF_SHORT, 1'b0, 1'b0, 24'h1C_E0F3, 1'b1);
      repeat (300) @(negedge ref_clk);
      chk({decodeDoneIrq, 24'(digCount - dc), 24'(begCount - bc)}, 0, "held");
      wr(ADDR_CONTROL, 8'h32);
      ms_frame(UF_SHORT, 1'b0, 1'b0, 24'h12_3456, 1'b1);
      svc(8'h32, 8'h02, 24'h12_3456, START_DF0_TRACK, 1'b1);
      chk({24'(digCount - dc), 24'(begCount - bc)}, 0, "suppressed");
      wr(ADDR_CONTROL, 8'h02);
      ms_frame(UF_SHORT, 1'b0, 1'b0, 24'h1C_E0F3, 1'b0);
      svc(8'h02, STAT_NO_SPR, 24'h0, 8'h00, 1'b0);
      rd(ADDR_STATUS, d, 1'b1); chk(d, 8'h00, "deselected read");
      $display("test faults done");
   endtask

   // inverted inputs; plain all-call replies, P2 or P2' suppress
   task automatic t_atc;
      logic [1:0] cs[4] = '{2'b00, 2'b10, 2'b01, 2'b00};
      logic [7:0] code[4] = '{8'h46, 8'h66, 8'h4E, 8'h46};
      int bc;
      wr(ADDR_CONTROL, 8'h0D);
      pol = 1'b1;
      hold(0, 5);
      wr(ADDR_CONTROL, 8'h0C);
      for (int k = 0; k < 4; k++) begin
         bc = begCount;
         atc(cs[k][1], cs[k][0]);
         svc(k < 2 ? 8'h0C : 8'h2C, code[k], 24'h0, 8'h00, 1'b0);
         chk(24'(begCount - bc), 24'(k == 0), "atc reply");
         if (k == 0) chk({24'(begWidth), 24'(begAt - p3At inside {[299:303]})}, {24'd10, 24'd1}, "atc timing");
      end
      $display("test atcrbs done");
   endtask

   // watchdog: whole run should finish well inside this span
   initial begin
      #1_000_000;
      n_fail++;
      report_and_stop;
   end

   // reset, then the scenarios in turn
   initial begin
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk) rst <= 1'b0;
      repeat (3) @(negedge ref_clk);
      t_regs;
      t_modes;
      t_faults;
      t_atc;
      report_and_stop;
   end
endmodule
`default_nettype wire

// ### hdl/intdec_core.sv
// Purpose: interrogation decoder, mode s uf0/uf16 and atcrbs mode c all-call
// Assumes: inputs synchronous to ref_clk; dpsk phase arrives as a level
// Notes: all state lives in one struct, registered by a single always_ff
`default_nettype none
// How it works
// RULE1 - answer only chip select inside 60h..6Fh
// RULE2 - write to 68h fires digitizer trigger
// RULE3 - own 24-bit address in 61h..63h
// RULE4 - own address loads operator value at power-up
// RULE5 - received address 6Ah..6Ch, start address 6Dh
// RULE6 - control D0 holds decoder, clears irq, dma
// RULE7 - control D1 picks atcrbs or mode s
// RULE8 - D2, D3 invert video and threshold
// RULE9 - D4, D5 suppress digitizer and reply triggers
// RULE10 - pulse needs video and threshold together
// RULE11 - dpsk decoding starts after P1, P2, P6
// RULE12 - 50 ns digitizer trigger after P1
// RULE13 - find sync reversal before decoding data
// RULE14 - check uf0/uf16, address, read RL, AQ
// RULE15 - tracking replies start at 23h or 6Fh
// RULE16 - acquisition replies start at FFh or 47h
// RULE17 - 100 ns reply pulse 128 us after SPR
// RULE18 - irq high after status, until reset
// RULE19 - processor reads, then pulses D0 to clear
// RULE20 - status D0 match, D1 uf0, D2 uf16
// RULE21 - status D3 RL, D4 AQ, D5 no reversal
// RULE22 - atcrbs reply 3 us after P3, then irq
// RULE23 - atcrbs status gives pulse combination code
// RULE24 - atcrbs reply pulse also 100 ns wide
module intdec_core #(
   parameter int unsigned REPLY_DELAY_CYC = intdec_pkg::REPLY_DELAY_CYC_DEF
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire intdec_pkg::intdec_bus_req_t busReq,
   output logic [7:0] busRdData,
   input wire logic [23:0] powerUpAddr,
   input wire logic videoIn,
   input wire logic thresholdIn,
   input wire logic dpskPhase,
   output logic digitizerTrigger,
   output logic replyStart,
   output logic decodeDoneIrq,
   output logic replyDmaRequest,
   output logic [7:0] replyDmaData,
   input wire logic replyDmaAck
);
   import intdec_pkg::*;

   intdec_state_t q;
   intdec_state_t d;
   logic csActive;
   logic inWindow;
   logic wrTake;
   logic rdTake;
   logic combNow;
   logic combRise;
   logic digLaunch;
   logic begLaunch;
   logic sampleBit;
   logic [6:0] bitNext;
   logic [23:0] shiftNext;
   logic isUf0;
   logic isUf16;
   logic addrMatch;

   // start address for a reply from RL and AQ
   function automatic logic [7:0] replySel(input logic rl, input logic aq);
      case ({rl, aq})
         2'b00: replySel = START_DF0_TRACK;
         2'b10: replySel = START_DF16_TRACK;
         2'b01: replySel = START_DF0_ACQ;
         default: replySel = START_DF16_ACQ;
      endcase
   endfunction

   // pulse combination code; with S1 the whole pattern sits one slot later
   function automatic logic [7:0] atcCode(input logic [6:0] seen);
      logic [7:0] base;
      base = ATC_BASE;
      if (seen[4]) begin
         if (seen[1]) base = base | ATC_P2;
         if (seen[0]) base = base | ATC_P2B;
         atcCode = base & ATC_MASK;
      end else begin
         if (seen[3]) base = base | ATC_P2;
         if (seen[2]) base = base | ATC_P2B;
         atcCode = (ATC_S1 | (base >> 1)) & ATC_MASK;
      end
   endfunction

   // valid all-call: P3 and P4 on time, no P2, no P2', no S1
   function automatic logic atcValid(input logic [6:0] seen);
      atcValid = seen[4] & seen[5] & ~seen[1] & ~seen[0];
   endfunction

   // read mux; write-only and unused slots read as zero
   function automatic logic [7:0] regRead(input logic [7:0] addr, input intdec_state_t s);
      case (addr)
         ADDR_STATUS: regRead = s.status;
         ADDR_RX_LOW: regRead = s.rxAddr[7:0];
         ADDR_RX_MID: regRead = s.rxAddr[15:8];
         ADDR_RX_HIGH: regRead = s.rxAddr[23:16];
         ADDR_REPLY_START: regRead = s.startAddr;
         default: regRead = 8'h00;
      endcase
   endfunction

   // bus decode; a write is taken once per strobe, on its first low cycle
   assign csActive = ~busReq.csN;
   assign inWindow = csActive & (busReq.addr[7:4] == WINDOW_PAGE); // [RULE1]
   assign wrTake = inWindow & ~busReq.wrN & ~q.wrSeen; // [RULE1]
   assign rdTake = inWindow & ~busReq.rdN; // [RULE1]

   // a pulse counts only where both detector lines agree
   assign combNow = (videoIn ^ q.ctrl[CTRL_INV_VIDEO]) & (thresholdIn ^ q.ctrl[CTRL_INV_THRESH]); // [RULE8] [RULE10]
   assign combRise = combNow & ~q.prevComb;

   // uplink format and address checks on the finished data block
   assign isUf0 = (q.ufField == UF_SHORT); // [RULE14]
   assign isUf16 = (q.ufField == UF_LONG); // [RULE14]
   assign addrMatch = (shiftNext == q.ownAddr); // [RULE14]

   // next-state logic for the whole decoder
   always_comb begin
      d = q;
      digLaunch = 1'b0;
      begLaunch = 1'b0;
      sampleBit = 1'b0;
      bitNext = q.bitCnt;
      shiftNext = q.shift;
      d.prevComb = combNow;
      d.prevPhase = dpskPhase;
      d.wrSeen = csActive & ~busReq.wrN;
      // strap-like load one edge after reset release
      if (q.loadPending) begin
         d.ownAddr = powerUpAddr; // [RULE4]
         d.loadPending = 1'b0;
      end
      if (wrTake) begin
         case (busReq.addr)
            ADDR_CONTROL: d.ctrl = busReq.wrData;
            ADDR_OWN_LOW: d.ownAddr[7:0] = busReq.wrData; // [RULE3]
            ADDR_OWN_MID: d.ownAddr[15:8] = busReq.wrData; // [RULE3]
            ADDR_OWN_HIGH: d.ownAddr[23:16] = busReq.wrData; // [RULE3]
            ADDR_MANUAL_TRIG: digLaunch = 1'b1; // [RULE2]
            default: ;
         endcase
      end
      d.rdData = rdTake ? regRead(busReq.addr, q) : 8'h00; // [RULE5]
      // ack drops the request; a new request in the same cycle wins below
      if (replyDmaAck) d.dmaReq = 1'b0;
      if (q.ctrl[CTRL_HOLD]) begin
         // held: nothing decodes, irq and dma drop
         d.fsm = S_IDLE; // [RULE6]
         d.irq = 1'b0; // [RULE6]
         d.dmaReq = 1'b0; // [RULE6]
         d.cnt = 16'h0000;
      end else begin
         case (q.fsm)
            S_IDLE: begin
               d.cnt = 16'h0000;
               d.atcSeen = 7'h00;
               if (combRise) d.fsm = q.ctrl[CTRL_MODE_S] ? S_PRE : S_ATC; // [RULE7]
            end
            S_PRE: begin
               d.cnt = q.cnt + 16'h0001;
               if (q.cnt == DIG_DELAY_CYC && !q.ctrl[CTRL_DIS_DIG]) digLaunch = 1'b1; // [RULE12] [RULE9]
               if (q.cnt == MS_P2_CYC && !combNow) d.fsm = S_IDLE; // [RULE11]
               if (q.cnt == MS_P6_CYC) d.fsm = combNow ? S_SPR : S_IDLE; // [RULE11]
            end
            S_SPR: begin
               d.cnt = q.cnt + 16'h0001;
               if (q.cnt >= SPR_EARLY_CYC && dpskPhase != q.prevPhase) begin
                  // reversal found: data chips are timed from here
                  d.fsm = S_DATA; // [RULE13]
                  d.cnt = 16'h0000;
                  d.chipTmr = DATA_FIRST_CYC;
                  d.bitCnt = 7'h00;
                  d.ufField = 5'h00;
                  d.refPhase = dpskPhase;
               end else if (q.cnt == SPR_LATE_CYC) begin
                  d.status = STAT_NO_SPR; // [RULE21]
                  d.irq = 1'b1; // [RULE18]
                  d.fsm = S_DONE;
               end
            end
            S_DATA: begin
               d.cnt = q.cnt + 16'h0001;
               if (q.chipTmr != 6'h00) begin
                  d.chipTmr = q.chipTmr - 6'h01;
               end else begin
                  // a one is a phase reversal against the previous chip
                  d.chipTmr = CHIP_LEN;
                  sampleBit = dpskPhase ^ q.refPhase;
                  d.refPhase = dpskPhase;
                  bitNext = q.bitCnt + 7'h01;
                  shiftNext = {q.shift[22:0], sampleBit};
                  d.bitCnt = bitNext;
                  d.shift = shiftNext;
                  if (bitNext <= UF_LAST_BIT) d.ufField = {q.ufField[3:0], sampleBit};
                  if (bitNext == RL_BIT) d.rl = sampleBit; // [RULE14]
                  if (bitNext == AQ_BIT) d.aq = sampleBit; // [RULE14]
                  if ((bitNext == SHORT_BITS && !isUf16) || bitNext == LONG_BITS) begin
                     d.status = {2'b00, 1'b0, q.aq, q.rl, isUf16, isUf0, addrMatch}; // [RULE20] [RULE21]
                     d.rxAddr = shiftNext;
                     d.startAddr = replySel(q.rl, q.aq); // [RULE15] [RULE16]
                     if (addrMatch && (isUf0 || isUf16)) begin
                        d.dmaReq = 1'b1; // [RULE15] [RULE16]
                        d.fsm = S_WAIT;
                     end else begin
                        d.irq = 1'b1; // [RULE18]
                        d.fsm = S_DONE;
                     end
                  end
               end
            end
            S_WAIT: begin
               d.cnt = q.cnt + 16'h0001;
               if (q.cnt == 16'(REPLY_DELAY_CYC - 1)) begin
                  begLaunch = ~q.ctrl[CTRL_DIS_PG]; // [RULE17] [RULE9]
                  d.irq = 1'b1; // [RULE18]
                  d.fsm = S_DONE;
               end
            end
            S_ATC: begin
               d.cnt = q.cnt + 16'h0001;
               for (int k = 0; k < 7; k++) begin
                  if (q.cnt == ATC_SAMPLE_CYC[k]) d.atcSeen[k] = combNow;
               end
               if (q.cnt == ATC_REPLY_CYC && atcValid(q.atcSeen)) begLaunch = ~q.ctrl[CTRL_DIS_PG]; // [RULE22]
               if (q.cnt == ATC_END_CYC) begin
                  d.status = atcCode(q.atcSeen); // [RULE23]
                  d.irq = 1'b1; // [RULE18] [RULE22]
                  d.fsm = S_DONE;
               end
            end
            S_DONE: d.fsm = S_DONE;
            default: d.fsm = S_IDLE;
         endcase
      end
      // fixed-width output pulses; a launched pulse always runs to its end
      if (digLaunch) begin
         d.digOut = 1'b1; // [RULE12]
         d.digCnt = DIG_LEN;
      end else if (q.digCnt != 3'h0) begin
         d.digCnt = q.digCnt - 3'h1;
      end else begin
         d.digOut = 1'b0;
      end
      if (begLaunch) begin
         d.begOut = 1'b1; // [RULE17] [RULE24]
         d.begCnt = BEGIN_LEN;
      end else if (q.begCnt != 4'h0) begin
         d.begCnt = q.begCnt - 4'h1;
      end else begin
         d.begOut = 1'b0;
      end
   end

   // single state register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.fsm <= S_IDLE;
         q.ctrl <= CTRL_RESET;
         q.loadPending <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign busRdData = q.rdData;
   assign digitizerTrigger = q.digOut;
   assign replyStart = q.begOut;
   assign decodeDoneIrq = q.irq;
   assign replyDmaRequest = q.dmaReq;
   assign replyDmaData = q.startAddr;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence s_digPulse;
      digitizerTrigger[*5] ##1 !digitizerTrigger;
   endsequence

   sequence s_begPulse;
      replyStart[*5] ##1 replyStart[*5] ##1 !replyStart;
   endsequence

   a_hold_clears_lines: assert property (q.ctrl[CTRL_HOLD] |=> !decodeDoneIrq && !replyDmaRequest) // [RULE6]
      else $error("irq or dma still set while decoder held");

   a_manual_trig_fires: assert property (wrTake && busReq.addr == ADDR_MANUAL_TRIG |=> s_digPulse) // [RULE2]
      else $error("manual trigger write gave no 50 ns pulse");

   a_dig_pulse_width: assert property ($rose(digitizerTrigger) && !$past(wrTake) |-> s_digPulse) // [RULE12]
      else $error("digitizer trigger width wrong");

   a_dig_after_p1: assert property ($rose(digitizerTrigger) && !$past(wrTake)
      |-> $past(q.fsm) == S_PRE && $past(q.cnt) == DIG_DELAY_CYC) // [RULE12]
      else $error("digitizer trigger not timed from P1");

   a_begin_width: assert property ($rose(replyStart) |-> s_begPulse) // [RULE24]
      else $error("reply start pulse not 100 ns");

   a_begin_masked: assert property ($rose(replyStart) |-> !$past(q.ctrl[CTRL_DIS_PG])) // [RULE9]
      else $error("reply start fired while disabled");

   a_irq_sticky: assert property (decodeDoneIrq && !q.ctrl[CTRL_HOLD] |=> decodeDoneIrq) // [RULE18]
      else $error("irq dropped without decoder reset");

   a_dma_start_addr: assert property ($rose(replyDmaRequest)
      |-> replyDmaData == replySel(q.status[3], q.status[4]) && q.status[0]
          && (q.status[1] || q.status[2])) // [RULE15]
      else $error("dma start address or status mismatch");

   a_no_spr_flag: assert property (q.fsm == S_SPR && q.cnt == SPR_LATE_CYC && !q.ctrl[CTRL_HOLD]
      && d.fsm == S_DONE |=> q.status == STAT_NO_SPR && decodeDoneIrq) // [RULE21]
      else $error("missing reversal not flagged");

   a_read_window: assert property (!rdTake |=> busRdData == 8'h00) // [RULE1]
      else $error("read data outside an accepted read");

   a_power_load: assert property ($fell(q.loadPending) |-> q.ownAddr == $past(powerUpAddr)) // [RULE4]
      else $error("own address not loaded at power-up");

   a_atc_code_mask: assert property (q.fsm == S_ATC && d.fsm == S_DONE |=> !q.status[7] && decodeDoneIrq) // [RULE23]
      else $error("atcrbs status bit 7 not masked");
endmodule
`default_nettype wire

// ### shared/intdec_pkg.sv
// Purpose: constants and types for the interrogation decoder
// Assumes: 100 MHz ref_clk, byte-wide register window 60h..6Fh
// Notes: times are kept in their own unit, cycle counts derive from them
`default_nettype none
package intdec_pkg;
   localparam int CYCLE_NS = 10;
   // register window and offsets
   localparam logic [3:0] WINDOW_PAGE = 4'h6;
   localparam logic [7:0] ADDR_CONTROL = 8'h60;
   localparam logic [7:0] ADDR_OWN_LOW = 8'h61;
   localparam logic [7:0] ADDR_OWN_MID = 8'h62;
   localparam logic [7:0] ADDR_OWN_HIGH = 8'h63;
   localparam logic [7:0] ADDR_MANUAL_TRIG = 8'h68;
   localparam logic [7:0] ADDR_STATUS = 8'h69;
   localparam logic [7:0] ADDR_RX_LOW = 8'h6A;
   localparam logic [7:0] ADDR_RX_MID = 8'h6B;
   localparam logic [7:0] ADDR_RX_HIGH = 8'h6C;
   localparam logic [7:0] ADDR_REPLY_START = 8'h6D;
   // control bits
   localparam int CTRL_HOLD = 0;
   localparam int CTRL_MODE_S = 1;
   localparam int CTRL_INV_VIDEO = 2;
   localparam int CTRL_INV_THRESH = 3;
   localparam int CTRL_DIS_DIG = 4;
   localparam int CTRL_DIS_PG = 5;
   localparam logic [7:0] CTRL_RESET = 8'h0D;
   // status codes
   localparam logic [7:0] STAT_NO_SPR = 8'h20;
   localparam logic [7:0] ATC_BASE = 8'h46;
   localparam logic [7:0] ATC_P2 = 8'h20;
   localparam logic [7:0] ATC_P2B = 8'h08;
   localparam logic [7:0] ATC_S1 = 8'h40;
   localparam logic [7:0] ATC_MASK = 8'h7F;
   // reply start addresses
   localparam logic [7:0] START_DF0_TRACK = 8'h23;
   localparam logic [7:0] START_DF16_TRACK = 8'h6F;
   localparam logic [7:0] START_DF0_ACQ = 8'hFF;
   localparam logic [7:0] START_DF16_ACQ = 8'h47;
   // uplink format fields
   localparam logic [4:0] UF_SHORT = 5'h00;
   localparam logic [4:0] UF_LONG = 5'h10;
   localparam logic [6:0] UF_LAST_BIT = 7'd5;
   localparam logic [6:0] RL_BIT = 7'd9;
   localparam logic [6:0] AQ_BIT = 7'd14;
   localparam logic [6:0] SHORT_BITS = 7'd56;
   localparam logic [6:0] LONG_BITS = 7'd112;
   // times
   localparam int DIG_DELAY_NS = 100;
   localparam int DIG_WIDTH_NS = 50;
   localparam int BEGIN_WIDTH_NS = 100;
   localparam int REPLY_DELAY_US = 128;
   localparam int MS_P2_NS = 2400;
   localparam int MS_P6_NS = 3700;
   localparam int SPR_EARLY_NS = 4500;
   localparam int SPR_LATE_NS = 5000;
   localparam int DATA_FIRST_NS = 620;
   localparam int CHIP_NS = 250;
   localparam int ATC_P3_NS = 8000;
   localparam int ATC_REPLY_US = 3;
   localparam int ATC_END_NS = 13000;
   // cycle counts
   localparam logic [15:0] DIG_DELAY_CYC = 16'((DIG_DELAY_NS + CYCLE_NS - 1) / CYCLE_NS);
   localparam logic [2:0] DIG_LEN = 3'(DIG_WIDTH_NS / CYCLE_NS - 1);
   localparam logic [3:0] BEGIN_LEN = 4'(BEGIN_WIDTH_NS / CYCLE_NS - 1);
   localparam int REPLY_DELAY_CYC_DEF = REPLY_DELAY_US * 1000 / CYCLE_NS;
   localparam logic [15:0] MS_P2_CYC = 16'(MS_P2_NS / CYCLE_NS);
   localparam logic [15:0] MS_P6_CYC = 16'(MS_P6_NS / CYCLE_NS);
   localparam logic [15:0] SPR_EARLY_CYC = 16'(SPR_EARLY_NS / CYCLE_NS);
   localparam logic [15:0] SPR_LATE_CYC = 16'(SPR_LATE_NS / CYCLE_NS);
   localparam logic [5:0] DATA_FIRST_CYC = 6'(DATA_FIRST_NS / CYCLE_NS);
   localparam logic [5:0] CHIP_LEN = 6'(CHIP_NS / CYCLE_NS - 1);
   localparam logic [15:0] ATC_REPLY_CYC = 16'((ATC_P3_NS + ATC_REPLY_US * 1000) / CYCLE_NS);
   localparam logic [15:0] ATC_END_CYC = 16'(ATC_END_NS / CYCLE_NS);
   // atcrbs sample points: P2', P2, S1-case P2', S1-case P2, P3, P4, S1-case P4
   localparam logic [6:0][15:0] ATC_SAMPLE_CYC = {16'(12400 / CYCLE_NS), 16'(10400 / CYCLE_NS),
      16'(8400 / CYCLE_NS), 16'(4400 / CYCLE_NS), 16'(3400 / CYCLE_NS), 16'(2400 / CYCLE_NS),
      16'(1400 / CYCLE_NS)};

   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_PRE = 3'b001, S_SPR = 3'b010, S_DATA = 3'b011,
      S_WAIT = 3'b100, S_ATC = 3'b101, S_DONE = 3'b110
   } intdec_fsm_t;

   typedef struct packed {
      logic csN;
      logic rdN;
      logic wrN;
      logic [7:0] addr;
      logic [7:0] wrData;
   } intdec_bus_req_t;

   typedef struct packed {
      intdec_fsm_t fsm;
      logic [15:0] cnt;
      logic [5:0] chipTmr;
      logic [6:0] bitCnt;
      logic [4:0] ufField;
      logic rl;
      logic aq;
      logic refPhase;
      logic prevComb;
      logic prevPhase;
      logic wrSeen;
      logic loadPending;
      logic [23:0] shift;
      logic [6:0] atcSeen;
      logic [7:0] ctrl;
      logic [7:0] status;
      logic [7:0] startAddr;
      logic [7:0] rdData;
      logic [23:0] ownAddr;
      logic [23:0] rxAddr;
      logic irq;
      logic dmaReq;
      logic digOut;
      logic begOut;
      logic [2:0] digCnt;
      logic [3:0] begCnt;
   } intdec_state_t;
endpackage
`default_nettype wire
